// ===== rtl/timer3_reload_capture.v
// How it works
// R1: Upper byte rollover sets sticky upper flag
// R2: Upper flag raises interrupt when enabled
// R3: Lower byte rollover sets sticky lower flag
// R4: Lower overflow interrupts when also enabled
// R5: Capture copies count to reload on fall
// R6: Split bit picks 16-bit or 8+8 mode
// R7: Run bit gates counting, upper only split
// R8: Split lower counter always runs
// R9: Alt field picks div12, ext/8, osc/8
// R10: Slow clocks synchronised to system clock
// R11: One alt clock shared, per-byte selects
// R12: Two read/write reload bytes
// R13: Count low byte readable and writable
// R14: 16-bit rollover loads full reload value
// R15: Split bytes reload from own reload byte
// R16: Byte select one picks system clock
// R17: Split interrupts on upper, optionally lower
// R18: Interrupt level follows flags and enables
// R19: Edge detect gives single-cycle enables
`timescale 1ns/10ps
`default_nettype none
`include "timer3_defs.vh"
module timer3_reload_capture (
  input wire sys_clk, // System clock, 10 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire [7:0] sfr_addr, // Register address
  input wire sfr_wr, // Write strobe, one cycle
  input wire [7:0] sfr_wdata, // Write data
  output reg [7:0] sfr_rdata, // Read data, one cycle late
  input wire timer_irq_enable, // Timer interrupt enable
  input wire upper_byte_system_clock_select, // Upper byte uses system clock
  input wire lower_byte_system_clock_select, // Lower byte uses system clock
  input wire ext_clk, // External oscillator clock
  input wire low_freq_oscillator, // Low-frequency oscillator
  output wire irq, // Interrupt request level
  output reg [7:0] timer_three_count_high // Upper count byte
);
  // ==========================================================
  // Storage
  reg [7:0] timer_three_control_r; // Control register
  reg [7:0] timer_three_reload_low_r; // Reload low
  reg [7:0] timer_three_reload_high_r; // Reload high
  reg [7:0] timer_three_count_low_r; // Count low
  reg [3:0] div12_r; // System clock prescaler
  reg [2:0] ext_div_r; // External edge divider
  reg [2:0] osc_div_r; // Oscillator edge divider
  reg [7:0] ctrl_nxt; // Next control
  reg [7:0] rl_low_nxt; // Next reload low
  reg [7:0] rl_high_nxt; // Next reload high
  reg [7:0] cnt_low_nxt; // Next count low
  reg [7:0] cnt_high_nxt; // Next count high
  reg upper_set; // Upper flag set event, overflow or capture
  reg lower_set; // Lower overflow event
  reg alt_tick; // Alternate clock enable
  wire ext_rise; // External clock edge
  wire osc_rise; // Oscillator rising edge
  wire osc_fall; // Oscillator falling edge
  wire div12_tick; // System clock / 12
  wire ext8_tick; // External / 8
  wire osc8_tick; // Oscillator / 8
  wire [3:0] ext_div_step; // Next external divider value
  wire [3:0] osc_div_step; // Next oscillator divider value
  wire low_tick; // Lower byte enable
  wire high_tick; // Upper byte enable
  wire split_mode_select; // Split field
  wire run_control; // Run field
  wire osc_capture_enable; // Capture field
  wire lower_overflow_irq_enable; // Low irq enable field
  wire [1:0] alt_clock_select; // Alternate clock field
  wire capture; // Capture event this cycle

  assign split_mode_select = timer_three_control_r[`BIT_SPLIT];
  assign run_control = timer_three_control_r[`BIT_RUN];
  assign osc_capture_enable = timer_three_control_r[`BIT_CAPTURE_EN];
  assign lower_overflow_irq_enable = timer_three_control_r[`BIT_LOWER_IRQ_EN];
  assign alt_clock_select = timer_three_control_r[`ALT_CLK_HI:`ALT_CLK_LO];

  // Wrapping divider step, shared by all prescalers
  function [3:0] wrap_inc;
    input [3:0] value;
    input [3:0] last;
    begin
      wrap_inc = (value == last) ? 4'h0 : value + 4'h1;
    end
  endfunction

  // ==========================================================
  // Slow clock synchronisers
  // R10: synchronise slow clocks
  edge_sync u_ext_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(ext_clk),
    .rise_pulse(ext_rise),
    .fall_pulse()
  );

  // R19: oscillator edge pulses
  edge_sync u_osc_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(low_freq_oscillator),
    .rise_pulse(osc_rise),
    .fall_pulse(osc_fall)
  );

  // ==========================================================
  // Prescalers
  // Slow dividers step through the shared 4-bit helper, top bit unused
  assign ext_div_step = wrap_inc({1'b0, ext_div_r}, {1'b0, `SLOW_LAST});
  assign osc_div_step = wrap_inc({1'b0, osc_div_r}, {1'b0, `SLOW_LAST});

  // Dividing edges, not levels, keeps each tick one cycle wide
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      div12_r <= 4'h0;
      ext_div_r <= 3'h0;
      osc_div_r <= 3'h0;
    end else begin
      div12_r <= wrap_inc(div12_r, `SYS_LAST);
      if (ext_rise) begin
        ext_div_r <= ext_div_step[2:0];
      end
      if (osc_rise) begin
        osc_div_r <= osc_div_step[2:0];
      end
    end
  end

  // R19: single-cycle count enables
  assign div12_tick = (div12_r == `SYS_LAST);
  assign ext8_tick = ext_rise & (ext_div_r == `SLOW_LAST);
  assign osc8_tick = osc_rise & (osc_div_r == `SLOW_LAST);

  // R9: alternate clock decode
  always @* begin
    case (alt_clock_select)
      `ALT_SYS_DIV12: alt_tick = div12_tick;
      `ALT_EXT_DIV8: alt_tick = ext8_tick;
      `ALT_OSC_DIV8: alt_tick = osc8_tick;
      // Reserved code never counts
      default: alt_tick = 1'b0;
    endcase
  end

  // R16: per-byte system clock select
  // R11: shared alternate clock
  assign low_tick = lower_byte_system_clock_select ? 1'b1 : alt_tick;
  assign high_tick = upper_byte_system_clock_select ? 1'b1 : alt_tick;

  assign capture = osc_capture_enable & osc_fall;

  // ==========================================================
  // Counter, reload and flag next state
  always @* begin
    cnt_low_nxt = timer_three_count_low_r;
    cnt_high_nxt = timer_three_count_high;
    rl_low_nxt = timer_three_reload_low_r;
    rl_high_nxt = timer_three_reload_high_r;
    ctrl_nxt = timer_three_control_r;
    upper_set = 1'b0;
    lower_set = 1'b0;
    // R6: mode select
    if (!split_mode_select) begin
      // R7: run gates whole counter; lower select clocks it
      if (run_control && low_tick) begin
        if (timer_three_count_low_r == `BYTE_MAX) begin
          // R3: lower rollover
          lower_set = 1'b1;
          if (timer_three_count_high == `BYTE_MAX) begin
            // R14: full reload on 16-bit rollover
            // R1: upper rollover flag
            upper_set = 1'b1;
            cnt_low_nxt = timer_three_reload_low_r;
            cnt_high_nxt = timer_three_reload_high_r;
          end else begin
            cnt_low_nxt = `BYTE_ZERO;
            cnt_high_nxt = timer_three_count_high + 8'h01;
          end
        end else begin
          cnt_low_nxt = timer_three_count_low_r + 8'h01;
        end
      end
    end else begin
      // R8: lower byte free-running in split mode
      if (low_tick) begin
        if (timer_three_count_low_r == `BYTE_MAX) begin
          // R15: lower reload from own byte
          // R3: lower rollover
          lower_set = 1'b1;
          cnt_low_nxt = timer_three_reload_low_r;
        end else begin
          cnt_low_nxt = timer_three_count_low_r + 8'h01;
        end
      end
      // R7: run gates upper byte only
      if (run_control && high_tick) begin
        if (timer_three_count_high == `BYTE_MAX) begin
          // R15: upper reload from own byte
          // R1: upper rollover flag
          upper_set = 1'b1;
          cnt_high_nxt = timer_three_reload_high_r;
        end else begin
          cnt_high_nxt = timer_three_count_high + 8'h01;
        end
      end
    end
    // R12: software writes to reload bytes
    // R13: software write to count low wins over counting
    if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_CONTROL: ctrl_nxt = sfr_wdata;
        `ADDR_RELOAD_LOW: rl_low_nxt = sfr_wdata;
        `ADDR_RELOAD_HIGH: rl_high_nxt = sfr_wdata;
        `ADDR_COUNT_LOW: cnt_low_nxt = sfr_wdata;
        // Other addresses belong to other blocks
        default: ctrl_nxt = ctrl_nxt;
      endcase
    end
    // R5: capture count into reload, wins over a write
    if (capture) begin
      rl_low_nxt = timer_three_count_low_r;
      rl_high_nxt = timer_three_count_high;
      upper_set = 1'b1;
    end
    // Hardware set wins over a software clear in the same cycle
    if (upper_set) begin
      ctrl_nxt[`BIT_UPPER_FLAG] = 1'b1;
    end
    if (lower_set) begin
      ctrl_nxt[`BIT_LOWER_FLAG] = 1'b1;
    end
  end

  // ==========================================================
  // State registers
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      timer_three_control_r <= `CTRL_RESET;
      timer_three_reload_low_r <= `BYTE_ZERO;
      timer_three_reload_high_r <= `BYTE_ZERO;
      timer_three_count_low_r <= `BYTE_ZERO;
      timer_three_count_high <= `BYTE_ZERO;
    end else begin
      timer_three_control_r <= ctrl_nxt;
      timer_three_reload_low_r <= rl_low_nxt;
      timer_three_reload_high_r <= rl_high_nxt;
      timer_three_count_low_r <= cnt_low_nxt;
      timer_three_count_high <= cnt_high_nxt;
    end
  end

  // ==========================================================
  // Registered read port; unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sfr_rdata <= `BYTE_ZERO;
    end else begin
      case (sfr_addr)
        `ADDR_CONTROL: sfr_rdata <= timer_three_control_r;
        `ADDR_RELOAD_LOW: sfr_rdata <= timer_three_reload_low_r;
        `ADDR_RELOAD_HIGH: sfr_rdata <= timer_three_reload_high_r;
        `ADDR_COUNT_LOW: sfr_rdata <= timer_three_count_low_r;
        default: sfr_rdata <= `BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Interrupt level straight from flop outputs
  // R2: upper flag request
  // R4: lower flag request with its enable
  // R17: split mode uses the same terms
  // R18: level held while flags stand
  assign irq = timer_irq_enable &
               (timer_three_control_r[`BIT_UPPER_FLAG] |
                (timer_three_control_r[`BIT_LOWER_FLAG] & lower_overflow_irq_enable));
endmodule
`default_nettype wire

// ===== rtl/timer3_defs.vh
`ifndef TIMER3_DEFS_VH
`define TIMER3_DEFS_VH
// ==========================================================
// Register addresses on the special-function bus
`define ADDR_CONTROL 8'h91
`define ADDR_RELOAD_LOW 8'h92
`define ADDR_RELOAD_HIGH 8'h93
`define ADDR_COUNT_LOW 8'h94
// ==========================================================
// Control register bit positions
`define BIT_UPPER_FLAG 7
`define BIT_LOWER_FLAG 6
`define BIT_LOWER_IRQ_EN 5
`define BIT_CAPTURE_EN 4
`define BIT_SPLIT 3
`define BIT_RUN 2
`define ALT_CLK_HI 1
`define ALT_CLK_LO 0
// ==========================================================
// Reset values and byte constants
`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hFF
`define CTRL_RESET 8'h00
// ==========================================================
// Alternate clock field codes
`define ALT_SYS_DIV12 2'b00
`define ALT_EXT_DIV8 2'b01
`define ALT_RESERVED 2'b10
`define ALT_OSC_DIV8 2'b11
// ==========================================================
// Divider ratios
`define SYS_DIV 12
`define SLOW_DIV 8
// Last divider states, sized to the divider registers
`define SYS_LAST 4'hB
`define SLOW_LAST 3'h7
`endif

// ===== rtl/edge_sync.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-flop synchroniser with edge pulses
module edge_sync (
  input wire sys_clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire async_in, // Slow clock from another source
  output reg rise_pulse, // One cycle on rising edge
  output reg fall_pulse // One cycle on falling edge
);
  reg meta_r; // First stage, read only by sync_r
  reg sync_r; // Second stage, safe to use
  reg last_r; // Previous synchronised value

  // Edges are taken from the second stage only, never the first
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_pulse <= sync_r & ~last_r;
      fall_pulse <= ~sync_r & last_r;
    end
  end
endmodule
`default_nettype wire

// ===== verif/timer3_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port-level checker for the reload and capture timer
module timer3_checker (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic timer_irq_enable, // Global interrupt enable
  input wire logic upper_byte_system_clock_select, // Upper byte fast clock
  input wire logic lower_byte_system_clock_select, // Lower byte fast clock
  input wire logic ext_clk, // External clock
  input wire logic low_freq_oscillator, // Slow oscillator
  input wire logic irq, // Interrupt level
  input wire logic [7:0] timer_three_count_high // Upper count byte
);
  logic [7:0] ctrl_sh_r; // Software view of control
  logic [7:0] rlh_sh_r; // Software view of reload high
  logic up_fast; // Upper byte steps every cycle
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Shadows: only bits that hardware never changes are trusted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_sh_r <= 8'h00;
      rlh_sh_r <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'h91) ctrl_sh_r <= sfr_wdata;
      if (sfr_addr == 8'h93) rlh_sh_r <= sfr_wdata;
    end
  end
  // Split, running, no capture, upper on system clock
  assign up_fast = ctrl_sh_r[3] & ctrl_sh_r[2] & ~ctrl_sh_r[4] & upper_byte_system_clock_select;
  // ==========================================================
  // Assertions
  chk_reset_clears: assert property ($rose(rst_n) |-> sfr_rdata == 8'h00 && !irq)
    else $error("outputs not cleared by reset");
  chk_irq_gated: assert property (!timer_irq_enable |-> !irq)
    else $error("irq raised while disabled");
  chk_irq_sticky: assert property ($fell(irq) && timer_irq_enable &&
    $past(timer_irq_enable && rst_n) |-> $past(sfr_wr && sfr_addr == 8'h91))
    else $error("irq dropped without a control write");
  chk_stop_holds: assert property ($past(!ctrl_sh_r[2] && rst_n) |->
    $stable(timer_three_count_high)) else $error("upper byte moved while stopped");
  chk_upper_step: assert property ($past(up_fast && rst_n) |-> timer_three_count_high ==
    ($past(timer_three_count_high) == 8'hFF ? $past(rlh_sh_r) :
    $past(timer_three_count_high) + 8'h01)) else $error("upper byte step wrong");
  chk_reload_back: assert property (sfr_wr && !ctrl_sh_r[4] &&
    (sfr_addr == 8'h92 || sfr_addr == 8'h93) ##1 !sfr_wr && sfr_addr == $past(sfr_addr)
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("reload byte readback wrong");
  chk_ctrl_back: assert property (sfr_wr && sfr_addr == 8'h91 ##1
    !sfr_wr && sfr_addr == 8'h91 |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 2))
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (sfr_addr < 8'h91 || sfr_addr > 8'h94 |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  // Main scenarios reached
  cov_irq_rise: cover property ($rose(irq));
  cov_upper_wrap: cover property (up_fast && timer_three_count_high == 8'hFF);
  cov_unmapped: cover property (sfr_addr == 8'h95);
endmodule
bind timer3_reload_capture timer3_checker i_timer3_checker (.sys_clk(sys_clk),
  .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
  .upper_byte_system_clock_select(upper_byte_system_clock_select),
  .lower_byte_system_clock_select(lower_byte_system_clock_select), .ext_clk(ext_clk),
  .low_freq_oscillator(low_freq_oscillator), .irq(irq),
  .timer_three_count_high(timer_three_count_high));
`default_nettype wire

// ===== verif/tb_timer3_reload_capture.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Register-level bench for the reload and capture timer
module tb_timer3_reload_capture;
  logic sys_clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Synchronous reset, active low
  logic [7:0] sfr_addr = 8'h00; // Register address
  logic sfr_wr = 1'b0; // Write strobe
  logic [7:0] sfr_wdata = 8'h00; // Write data
  logic irq_en = 1'b1; // Global interrupt enable
  logic up_sel = 1'b0; // Upper byte fast clock
  logic lo_sel = 1'b1; // Lower byte fast clock
  logic ext_clk = 1'b0; // External clock
  logic osc = 1'b0; // Slow oscillator
  wire [7:0] sfr_rdata; // Read data
  wire irq; // Interrupt level
  wire [7:0] count_high; // Upper count byte
  int miscompares = 0; // Mismatch count
  int checks = 0; // Comparison count
  logic [7:0] h0; // Upper byte at window start
  logic [1:0] codes [3] = '{2'h1, 2'h2, 2'h3}; // Slow and reserved alternate codes
  logic [7:0] gain [3] = '{8'h08, 8'h00, 8'h08}; // Ticks per 64 slow edges
  timer3_reload_capture i_timer3_reload_capture (.sys_clk(sys_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(irq_en), .upper_byte_system_clock_select(up_sel),
    .lower_byte_system_clock_select(lo_sel), .ext_clk(ext_clk), .low_freq_oscillator(osc),
    .irq(irq), .timer_three_count_high(count_high));
  // ==========================================================
  // Clock and watchdog
  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    #8_000_000;
    miscompares++;
    results();
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Write strobe stands for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  // Read data follows the sampled address by exactly one edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    @(posedge sys_clk);
    #1 chk($sformatf("register %h", a), sfr_rdata, exp);
  endtask
  // Slow sources run only while a test wants them
  task automatic slow(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      ext_clk <= 1'b1;
      osc <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_clk <= 1'b0;
      osc <= 1'b0;
    end
  endtask
  task automatic results;
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 8'h91; a <= 8'h95; a++) rd(a[7:0], 8'h00);
    wr(8'h92, 8'h34);
    rd(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    rd(8'h93, 8'h12);
    wr(8'h94, 8'h3C);
    rd(8'h94, 8'h3C);
    wr(8'h91, 8'h23);
    rd(8'h91, 8'h23);
    // Full 16-bit run up to the first rollover
    wr(8'h91, 8'h04);
    for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge sys_clk) #1;
    // Flags must come from the rollover itself, before software touches them
    rd(8'h91, 8'hC4);
    wr(8'h91, 8'hC0);
    #1 chk("count_high", count_high, 8'h12);
    rd(8'h94, 8'h38);
    rd(8'h91, 8'hC0);
    chk("irq", {7'h00, irq}, 8'h01);
    @(posedge sys_clk) irq_en <= 1'b0;
    #1 chk("irq", {7'h00, irq}, 8'h00);
    @(posedge sys_clk) irq_en <= 1'b1;
    wr(8'h91, 8'h40);
    #1 chk("irq", {7'h00, irq}, 8'h00);
    wr(8'h91, 8'h60);
    #1 chk("irq", {7'h00, irq}, 8'h01);
    wr(8'h91, 8'h00);
    #1 chk("irq", {7'h00, irq}, 8'h00);
    // Capture of the frozen count on a slow falling edge
    wr(8'h91, 8'h10);
    slow(1);
    repeat (4) @(posedge sys_clk);
    rd(8'h92, 8'h38);
    rd(8'h93, 8'h12);
    rd(8'h91, 8'h90);
    chk("irq", {7'h00, irq}, 8'h01);
    // Split mode: low byte free, high byte gated
    wr(8'h91, 8'h08);
    repeat (300) @(posedge sys_clk);
    #1 chk("count_high", count_high, 8'h12);
    rd(8'h91, 8'h48);
    wr(8'h93, 8'h00);
    @(posedge sys_clk) up_sel <= 1'b1;
    wr(8'h91, 8'h0C);
    repeat (300) @(posedge sys_clk);
    rd(8'h91, 8'hCC);
    // Alternate clocks: divide by 12, then the slow sources
    @(posedge sys_clk) up_sel <= 1'b0;
    wr(8'h91, 8'h0C);
    repeat (3) @(posedge sys_clk);
    #1 h0 = count_high;
    repeat (240) @(posedge sys_clk);
    #1 chk("count_high", count_high, h0 + 8'h14);
    // Lower byte now follows the shared alternate clock as well
    @(posedge sys_clk) lo_sel <= 1'b0;
    foreach (codes[k]) begin
      wr(8'h91, {6'h03, codes[k]});
      wr(8'h94, 8'h00);
      #1 h0 = count_high;
      slow(64);
      repeat (6) @(posedge sys_clk);
      #1 chk("count_high", count_high, h0 + gain[k]);
      rd(8'h94, gain[k]);
    end
    results();
  end
endmodule
`default_nettype wire
